// [logic/cbm_lane_if.sv]
// Interface carrying one address lane between the top and a correction unit.
`default_nettype none
interface cbm_lane_if;
   logic active;
   logic word_only;
   logic [15:0] start_addr;
   logic [15:0] end_addr;
   logic [15:0] cur_addr;
   logic [15:0] step;
   logic [15:0] new_addr;
   logic wrapped;
   modport top (output active, output word_only, output start_addr, output end_addr,
                output cur_addr, output step, input new_addr, input wrapped);
   modport unit (input active, input word_only, input start_addr, input end_addr,
                 input cur_addr, input step, output new_addr, output wrapped);
endinterface : cbm_lane_if
`default_nettype wire

// [logic/cbm_modulo_unit.sv]
// Combinational modulo correction of one effective address update.
`default_nettype none
module cbm_modulo_unit (
   cbm_lane_if.unit lane // One address lane.
);
   logic signed [17:0] sum;
   logic signed [17:0] lo;
   logic signed [17:0] hi;
   logic signed [17:0] len;
   logic signed [17:0] fixed;

   // Wide signed sum so that a step across the 64 Kbyte edge is still seen as a crossing.
   always_comb begin
      sum = $signed({2'b00, lane.cur_addr}) + $signed({{2{lane.step[15]}}, lane.step});
      lo = $signed({2'b00, lane.start_addr});
      hi = $signed({2'b00, lane.end_addr});
      len = hi - lo + 18'sd1;
      fixed = sum;
      lane.wrapped = 1'b0;
      // Both edges are checked only for an active lane, which makes buffers of any length bidirectional.
      if (lane.active && (sum > hi)) begin
         fixed = sum - len;
         lane.wrapped = 1'b1;
      end else if (lane.active && (sum < lo)) begin
         fixed = sum + len;
         lane.wrapped = 1'b1;
      end
      lane.new_addr = fixed[15:0];
      if (lane.active && lane.word_only) begin
         lane.new_addr[0] = 1'b0;
      end
   end
endmodule : cbm_modulo_unit
`default_nettype wire

// [logic/cbm_pkg.sv]
// Package of constants for the circular buffer modulo address correction block.
`default_nettype none
package cbm_pkg;
   localparam int ADDR_W = 16;
   localparam int REG_AW = 4;
   localparam int LANES = 3;
   // Lane numbering: X read, X write, Y.
   localparam int LANE_XR = 0;
   localparam int LANE_XW = 1;
   localparam int LANE_Y = 2;
   // Register indices on the plain register port.
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_X_START = 4'h1;
   localparam logic [3:0] OFS_X_END = 4'h2;
   localparam logic [3:0] OFS_Y_START = 4'h3;
   localparam logic [3:0] OFS_Y_END = 4'h4;
   localparam logic [3:0] OFS_WRAP_STATUS = 4'h5;
   // Control field layout.
   localparam int X_SEL_LSB = 0;
   localparam int Y_SEL_LSB = 4;
   localparam int SEL_W = 4;
   localparam int X_EN_BIT = 15;
   localparam int Y_EN_BIT = 14;
   localparam logic [15:0] CONTROL_MASK = 16'hc0ff;
   localparam logic [3:0] SEL_NONE = 4'hf;
   // Reset values.
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] BOUND_RESET = 16'h0000;
endpackage : cbm_pkg
`default_nettype wire

// [logic/cbm_top.sv]
// Circular buffer modulo addressing: registers, lane selection and result registers.
//
// The placing of the registers and the plain strobed port were decided locally.
`default_nettype none
module cbm_top (
   input wire logic clock, // Core clock, 200 MHz.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic [3:0] reg_addr, // Register index.
   input wire logic [15:0] reg_wdata, // Register write data.
   input wire logic reg_wr, // Write strobe, one cycle.
   input wire logic reg_rd, // Read strobe, one cycle.
   output logic [15:0] reg_rdata, // Read data, valid the cycle after the strobe.
   input wire logic [2:0] agu_valid, // Update request per lane.
   input wire logic [2:0][3:0] agu_ptr, // Working pointer number per lane.
   input wire logic [2:0][15:0] agu_addr, // Current pointer value per lane.
   input wire logic [2:0][15:0] agu_step, // Signed byte step per lane.
   output logic [2:0] agu_done, // Result valid, one cycle after request.
   output logic [2:0][15:0] agu_addr_out, // Corrected pointer value per lane.
   output logic [2:0] agu_wrapped // Result was wrapped by modulo correction.
);
   typedef struct packed {
      logic [15:0] control;
      logic [15:0] x_buffer_start;
      logic [15:0] x_buffer_end;
      logic [15:0] y_buffer_start;
      logic [15:0] y_buffer_end;
      logic [2:0] wrap_sticky;
      logic [15:0] rdata;
      logic [2:0] done;
      logic [2:0] wrapped;
      logic [2:0][15:0] result;
   } cbm_state_t;

   cbm_state_t state;
   cbm_state_t next_state;
   logic [3:0] x_pointer_select;
   logic [3:0] y_pointer_select;
   logic x_circular_enable;
   logic y_circular_enable;
   logic x_on;
   logic y_on;
   logic [2:0] lane_active;
   logic [2:0][15:0] lane_new;
   logic [2:0] lane_wrap;

   cbm_lane_if lane [3] ();

   // Control fields decoded from the stored control word.
   assign x_pointer_select = state.control[cbm_pkg::X_SEL_LSB +: cbm_pkg::SEL_W];
   assign y_pointer_select = state.control[cbm_pkg::Y_SEL_LSB +: cbm_pkg::SEL_W];
   assign x_circular_enable = state.control[cbm_pkg::X_EN_BIT];
   assign y_circular_enable = state.control[cbm_pkg::Y_EN_BIT];
   // All ones in a select field switches that space off regardless of its enable bit.
   assign x_on = x_circular_enable && (x_pointer_select != cbm_pkg::SEL_NONE);
   assign y_on = y_circular_enable && (y_pointer_select != cbm_pkg::SEL_NONE);

   // Only the selected pointer is corrected; X lanes also serve program space pointers.
   assign lane_active[cbm_pkg::LANE_XR] = x_on
      && (agu_ptr[cbm_pkg::LANE_XR] == x_pointer_select);
   assign lane_active[cbm_pkg::LANE_XW] = x_on
      && (agu_ptr[cbm_pkg::LANE_XW] == x_pointer_select);
   assign lane_active[cbm_pkg::LANE_Y] = y_on
      && (agu_ptr[cbm_pkg::LANE_Y] == y_pointer_select);

   // One correction unit per address generator; X lanes share the X bounds.
   for (genvar i = 0; i < cbm_pkg::LANES; i++) begin : g_lane
      localparam bit IS_Y = (i == cbm_pkg::LANE_Y);
      assign lane[i].active = lane_active[i];
      assign lane[i].word_only = IS_Y;
      assign lane[i].start_addr = IS_Y ? state.y_buffer_start : state.x_buffer_start;
      assign lane[i].end_addr = IS_Y ? state.y_buffer_end : state.x_buffer_end;
      assign lane[i].cur_addr = agu_addr[i];
      assign lane[i].step = agu_step[i];
      assign lane_new[i] = lane[i].new_addr;
      assign lane_wrap[i] = lane[i].wrapped;
      cbm_modulo_unit u_unit (
         .lane(lane[i].unit)
      );
   end

   // Next state: register writes, read data, lane results and sticky wrap flags.
   always_comb begin
      next_state = state;
      next_state.rdata = 16'h0000;
      if (reg_wr) begin
         case (reg_addr)
            cbm_pkg::OFS_CONTROL: begin
               next_state.control = reg_wdata & cbm_pkg::CONTROL_MASK;
            end
            cbm_pkg::OFS_X_START: begin
               next_state.x_buffer_start = reg_wdata;
            end
            cbm_pkg::OFS_X_END: begin
               next_state.x_buffer_end = reg_wdata;
            end
            cbm_pkg::OFS_Y_START: begin
               next_state.y_buffer_start = reg_wdata;
            end
            cbm_pkg::OFS_Y_END: begin
               next_state.y_buffer_end = reg_wdata;
            end
            cbm_pkg::OFS_WRAP_STATUS: begin
               next_state.wrap_sticky = state.wrap_sticky & ~reg_wdata[2:0];
            end
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            cbm_pkg::OFS_CONTROL: next_state.rdata = state.control;
            cbm_pkg::OFS_X_START: next_state.rdata = state.x_buffer_start;
            cbm_pkg::OFS_X_END: next_state.rdata = state.x_buffer_end;
            cbm_pkg::OFS_Y_START: next_state.rdata = state.y_buffer_start;
            cbm_pkg::OFS_Y_END: next_state.rdata = state.y_buffer_end;
            cbm_pkg::OFS_WRAP_STATUS: next_state.rdata = {13'h0000, state.wrap_sticky};
            default: next_state.rdata = 16'h0000;
         endcase
      end
      // A wrap in the same cycle as a clear keeps its flag set.
      next_state.wrap_sticky = next_state.wrap_sticky | (lane_wrap & agu_valid);
      next_state.done = agu_valid;
      next_state.wrapped = lane_wrap & agu_valid;
      for (int i = 0; i < cbm_pkg::LANES; i++) begin
         if (agu_valid[i]) begin
            next_state.result[i] = lane_new[i];
         end
      end
   end

   // The single state register.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
         state.control <= cbm_pkg::CONTROL_RESET;
         state.x_buffer_start <= cbm_pkg::BOUND_RESET;
         state.x_buffer_end <= cbm_pkg::BOUND_RESET;
         state.y_buffer_start <= cbm_pkg::BOUND_RESET;
         state.y_buffer_end <= cbm_pkg::BOUND_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign agu_done = state.done;
   assign agu_addr_out = state.result;
   assign agu_wrapped = state.wrapped;

   // Checks on the delivered results.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic [2:0][15:0] plain_sum;
   always_comb begin
      for (int i = 0; i < cbm_pkg::LANES; i++) begin
         plain_sum[i] = agu_addr[i] + agu_step[i];
      end
   end

   a_y_word_aligned: assert property (
      agu_valid[2] && lane_active[2] |=> agu_addr_out[2][0] == 1'b0)
      else $error("Y modulo result not word aligned.");
   a_xr_sel_none: assert property (
      agu_valid[0] && x_pointer_select == 4'hf |=> !agu_wrapped[0]
         && agu_addr_out[0] == $past(plain_sum[0]))
      else $error("X read corrected while select is all ones.");
   a_xw_sel_none: assert property (
      agu_valid[1] && x_pointer_select == 4'hf |=> agu_addr_out[1] == $past(plain_sum[1]))
      else $error("X write corrected while select is all ones.");
   a_y_sel_none: assert property (
      agu_valid[2] && y_pointer_select == 4'hf |=> agu_addr_out[2] == $past(plain_sum[2]))
      else $error("Y corrected while select is all ones.");
   a_x_enable_off: assert property (
      agu_valid[0] && !state.control[15] |=> !agu_wrapped[0])
      else $error("X wrapped with enable bit clear.");
   a_y_enable_off: assert property (
      agu_valid[2] && !state.control[14] |=> !agu_wrapped[2])
      else $error("Y wrapped with enable bit clear.");
   a_x_stays_inside: assert property (
      agu_valid[0] && lane_active[0] && agu_addr[0] >= state.x_buffer_start
         && agu_addr[0] <= state.x_buffer_end && state.x_buffer_end >= state.x_buffer_start
         && (agu_step[0] == 16'h0002 || agu_step[0] == 16'hfffe)
      |=> agu_addr_out[0] >= $past(state.x_buffer_start)
         && agu_addr_out[0] <= $past(state.x_buffer_end))
      else $error("X pointer left its buffer.");
   a_x_wrap_start: assert property (
      agu_valid[0] && lane_active[0] && agu_addr[0] == state.x_buffer_end
         && agu_step[0] == 16'h0001 && state.x_buffer_end != 16'hffff
      |=> agu_addr_out[0] == $past(state.x_buffer_start) && agu_wrapped[0])
      else $error("X pointer did not wrap to start.");
   a_other_ptr: assert property (
      agu_valid[1] && agu_ptr[1] != x_pointer_select |=> !agu_wrapped[1])
      else $error("Unselected pointer was corrected.");
   a_bound_read: assert property (
      reg_wr && reg_addr == 4'h1 ##1 reg_rd && reg_addr == 4'h1 && !reg_wr
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("X start readback mismatch.");
   a_done_timing: assert property (
      agu_valid[2] |=> agu_done[2] ##1 (agu_done[2] == $past(agu_valid[2])))
      else $error("Done does not follow request by one cycle.");

   c_x_wrap_up: cover property (agu_valid[0] && lane_active[0] && agu_step[0][15] == 1'b0
      ##1 agu_wrapped[0]);
   c_x_wrap_down: cover property (agu_valid[1] && lane_active[1] && agu_step[1][15]
      ##1 agu_wrapped[1]);
   c_y_wrap: cover property (agu_valid[2] ##1 agu_wrapped[2]);
   c_sticky_read: cover property (reg_rd && reg_addr == 4'h5 && state.wrap_sticky != 3'h0);
endmodule : cbm_top
`default_nettype wire

// [tb/cbm_agu_model.sv]
// Behavioural model of the core address pipeline that feeds the modulo lanes.
`default_nettype none
module cbm_agu_model (
   input wire logic clock, // Core clock.
   output logic [2:0] agu_valid, // Request per lane.
   output logic [2:0][3:0] agu_ptr, // Pointer number per lane.
   output logic [2:0][15:0] agu_addr, // Pointer value per lane.
   output logic [2:0][15:0] agu_step // Byte step per lane.
);
   timeunit 1ns;
   timeprecision 1ps;
   // Lanes start quiet so that nothing is requested during reset.
   initial begin
      agu_valid = '0;
      agu_ptr = '0;
      agu_addr = '0;
      agu_step = '0;
   end
   // One request held for exactly one edge, then the lane lines are inverted, so a design that
   // samples them outside the request cannot be saved by a stale value.
   task automatic issue(input int l, input logic [3:0] p, input logic [15:0] a, s);
      @(posedge clock);
      agu_valid[l] <= 1'b1;
      agu_ptr[l] <= p;
      agu_addr[l] <= a;
      agu_step[l] <= s;
      @(posedge clock);
      agu_valid[l] <= 1'b0;
      agu_ptr[l] <= ~p;
      agu_addr[l] <= ~a;
      agu_step[l] <= ~s;
   endtask
endmodule // cbm_agu_model
`default_nettype wire

// [tb/tb_cbm_top.sv]
// Self-checking testbench of the circular buffer modulo block.
`default_nettype none
module tb_cbm_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] reg_addr = '0;
   logic [15:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic rd_pend = 1'b0;
   logic [15:0] ctl = '0, xs = '0, xe = '0, ys = '0, ye = '0, lf = 16'h2aec, r;
   logic [15:0] reg_rdata;
   logic [2:0] agu_valid, agu_done, agu_wrapped;
   logic [2:0][3:0] agu_ptr;
   logic [2:0][15:0] agu_addr, agu_step, agu_addr_out;
   logic [16:0] q[3][$];
   logic [15:0] rq[$];
   int n_fail = 0, comparisons = 0, cyc = 0;
   cbm_top i_cbm_top (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .agu_valid(agu_valid), .agu_ptr(agu_ptr), .agu_addr(agu_addr), .agu_step(agu_step),
      .agu_done(agu_done), .agu_addr_out(agu_addr_out), .agu_wrapped(agu_wrapped));
   cbm_agu_model i_cbm_agu_model (.clock(clock), .agu_valid(agu_valid), .agu_ptr(agu_ptr),
      .agu_addr(agu_addr), .agu_step(agu_step));
   always #2.5 clock = ~clock;
   // Pseudo-random source, a 16-bit shift register with fixed start.
   function logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("counts: %0d compared, %0d failed", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      case (a)
         4'h0: ctl = d & 16'hc0ff;
         4'h1: xs = d;
         4'h2: xe = d;
         4'h3: ys = d;
         4'h4: ye = d;
         default: ;
      endcase
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      rq.push_back(e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask
   // Expected lane result worked out from the stored configuration, wrap flag on top.
   task automatic req(input int l, input logic [3:0] p, input logic [15:0] a, s);
      logic y, act, w;
      logic signed [17:0] sum, st, en, len;
      y = (l == 2);
      act = (y ? ctl[14] : ctl[15]) && (y ? ctl[7:4] : ctl[3:0]) != 4'hf;
      act = act && p == (y ? ctl[7:4] : ctl[3:0]);
      st = {2'b00, y ? ys : xs};
      en = {2'b00, y ? ye : xe};
      len = en - st + 18'sd1;
      sum = {2'b00, a} + {{2{s[15]}}, s};
      w = act && (sum > en || sum < st);
      if (act && sum > en) sum = sum - len;
      else if (act && sum < st) sum = sum + len;
      if (act && y) sum[0] = 1'b0;
      q[l].push_back({w, sum[15:0]});
      i_cbm_agu_model.issue(l, p, a, s);
   endtask
   // Watcher: each result or read answer is matched against the oldest note.
   always @(posedge clock) begin
      for (int i = 0; i < 3; i++) begin
         if (agu_done[i] === 1'b1) begin
            if (q[i].size() == 0) chk(17'h1ffff, 17'h0);
            else chk({agu_wrapped[i], agu_addr_out[i]}, q[i].pop_front());
         end
      end
      if (rd_pend) chk({1'b0, reg_rdata}, {1'b0, rq.pop_front()});
      rd_pend <= reg_rd;
   end
   // Hang guard; the whole sequence needs well under a thousand cycles.
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         end_sim();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) rd(i[3:0], 16'h0000);
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'hc0ff);
      for (int i = 1; i < 5; i++) begin
         r = rnd();
         wr(i[3:0], r);
         rd(i[3:0], r);
      end
      $display("test registers done");
      wr(4'h1, 16'h1000);
      wr(4'h2, 16'h100f);
      wr(4'h3, 16'h2000);
      wr(4'h4, 16'h207f);
      // Stack pointers 14 and 15 are never chosen as the modulo pointer.
      wr(4'h0, 16'hc053);
      req(0, 4'h3, 16'h100e, 16'h0002);
      req(1, 4'h3, 16'h1000, 16'hfffe);
      req(0, 4'h4, 16'h100e, 16'h0002);
      req(2, 4'h5, 16'h207e, 16'h0002);
      req(2, 4'h5, 16'h2001, 16'h0000);
      req(2, 4'h5, 16'h2000, 16'hfffe);
      // Every lane wrapped above, so all three sticky flags must be set; then clear them.
      rd(4'h5, 16'h0007);
      wr(4'h5, 16'h0007);
      rd(4'h5, 16'h0000);
      $display("test wrap done");
      for (int m = 0; m < 3; m++) begin
         wr(4'h0, m == 0 ? 16'hc0f3 : m == 1 ? 16'h4053 : 16'hc0f3);
         if (m == 2) wr(4'h0, 16'h80f3);
         req(0, 4'h3, 16'h100e, 16'h0002);
         req(1, 4'h3, 16'h1000, 16'hfffe);
         req(2, 4'hf, 16'h207e, 16'h0002);
      end
      $display("test disable done");
      wr(4'h1, 16'h0000);
      wr(4'h2, 16'hffff);
      wr(4'h0, 16'h80f3);
      req(0, 4'h3, 16'hfffe, 16'h0002);
      req(1, 4'h3, 16'h0000, 16'hfffe);
      $display("test full length done");
      wr(4'h1, 16'h1000);
      wr(4'h2, 16'h100f);
      wr(4'h0, 16'hc053);
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         if (r[1:0] == 2'b10) req(2, r[2] ? 4'h5 : 4'h3, 16'h2000 | (r & 16'h007f),
            r[15] ? 16'hfffe : 16'h0002);
         else req(r[0], r[2] ? 4'h3 : 4'h2, 16'h1000 | (r & 16'h000f),
            r[15] ? 16'hfffe : 16'h0002);
      end
      $display("test random done");
      repeat (3) @(posedge clock);
      chk(17'(q[0].size() + q[1].size() + q[2].size() + rq.size()), 17'h0);
      end_sim();
   end
endmodule // tb_cbm_top
`default_nettype wire
